// ==== rtpc_ctrl.sv ====
/*
  Resistive touch panel control: switch matrix, mode and bias select,
  converter input routing, and touch-detect edge events.
  Assumes a plain register port on core_clk and asynchronous comparator
  outputs from the panel front end; standby comes from system logic.
*/
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module rtpc_ctrl
  import rtpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic standby,
  input wire logic cmp_xp,
  input wire logic cmp_xm,
  output rtpc_drive_t drive,
  output logic panel_event
);

  // ==========================================================
  // Declarations
  rtpc_ctrl_t ctrl_q;           // Panel control register
  rtpc_ctrl_t ctrl_d;
  logic press_q;                // Sticky press flag
  logic press_d;
  logic release_q;              // Sticky release flag
  logic release_d;
  logic level_q;                // Previous synced detect level
  logic level_d;
  logic [31:0] rdata_q;         // Read data, one cycle after strobe
  logic [31:0] rdata_d;
  logic event_q;                // One-cycle event pulse
  logic event_d;
  rtpc_drive_t drive_q;         // Registered switch drive
  rtpc_drive_t drive_d;
  logic [1:0] cmp_sync;         // Synchronised comparator levels
  logic detect_lvl;             // Low while panel pressed
  logic fall_seen;              // Press edge this cycle
  logic rise_seen;              // Release edge this cycle

  // ==========================================================
  // Address decode
  // One compare shared by the write and read paths, so both always
  // agree on which offsets are mapped
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return (addr == ofs);
  endfunction : addr_hit

  // ==========================================================
  // Comparator synchronisation
  // two-stage sync first
  // Pins are asynchronous, so no logic here reads them directly
  rtpc_sync #(
    .WIDTH(2)
  ) i_rtpc_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in({cmp_xm, cmp_xp}),
    .sync_out(cmp_sync)
  );

  // ==========================================================
  // Edge detector next values
  always_comb begin
    detect_lvl = cmp_sync[0] & cmp_sync[1];
    // enabled edges only; standby does not gate this
    fall_seen = ctrl_q.fall_en & level_q & ~detect_lvl;
    rise_seen = ctrl_q.rise_en & ~level_q & detect_lvl;
    // Level kept for the next compare
    level_d = detect_lvl;
    event_d = fall_seen | rise_seen;
  end

  // Edge detector registers
  // Level resets high, the untouched idle, so reset makes no false edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      level_q <= 1'b1;
      event_q <= 1'b0;
    end else begin
      level_q <= level_d;
      event_q <= event_d;
    end
  end

  // ==========================================================
  // Control and sticky status next values
  always_comb begin
    ctrl_d = ctrl_q;
    press_d = press_q;
    release_d = release_q;
    // Writes; unmapped offsets are ignored
    if (reg_wr) begin
      if (addr_hit(reg_addr, RTPC_CTRL_OFS)) begin
        // Bits above the press enable are dropped
        ctrl_d = rtpc_ctrl_t'(reg_wdata[RTPC_FALL_BIT:0]);
      end else if (addr_hit(reg_addr, RTPC_STAT_OFS)) begin
        // Write one to clear
        if (reg_wdata[RTPC_PRESS_BIT]) begin
          press_d = 1'b0;
        end
        if (reg_wdata[RTPC_RELEASE_BIT]) begin
          release_d = 1'b0;
        end
      end
    end
    // New events win over a clear in the same cycle, so none is lost
    if (fall_seen) begin
      press_d = 1'b1;
    end
    if (rise_seen) begin
      release_d = 1'b1;
    end
  end

  // Control and sticky status registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= rtpc_ctrl_t'(RTPC_CTRL_RST[RTPC_FALL_BIT:0]);
      press_q <= 1'b0;
      release_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      press_q <= press_d;
      release_q <= release_d;
    end
  end

  // ==========================================================
  // Read data next value
  always_comb begin
    // Zero unless a read is taken; unmapped offsets read zero too
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (addr_hit(reg_addr, RTPC_CTRL_OFS)) begin
        rdata_d[RTPC_FALL_BIT:0] = ctrl_q;
      end else if (addr_hit(reg_addr, RTPC_STAT_OFS)) begin
        rdata_d[RTPC_PRESS_BIT] = press_q;
        rdata_d[RTPC_RELEASE_BIT] = release_q;
        rdata_d[RTPC_LEVEL_BIT] = level_q;
      end
    end
  end

  // Read data register; stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Switch matrix and bias next values
  always_comb begin
    drive_d.gnd_on = ctrl_q.gnd;
    drive_d.pwr_on = ctrl_q.pwr & ~ctrl_q.gnd;
    // mode field selects bias and routing
    unique case (ctrl_q.mode)
      RTPC_MODE_DETECT: begin
        // Resistor bias costs nothing until touched, so kept in standby
        drive_d.bias_active = 1'b0;
        drive_d.bias_resistor = 1'b1;
        drive_d.adc_sel = {1'b0, ctrl_q.asel};
      end
      RTPC_MODE_PRESSURE: begin
        drive_d.bias_active = ~standby;
        drive_d.bias_resistor = 1'b0;
        drive_d.adc_sel = RTPC_ADC_CURRENT;
      end
      RTPC_MODE_POS_A, RTPC_MODE_POS_B: begin
        // Active bias drops in standby to save power
        drive_d.bias_active = ~standby;
        drive_d.bias_resistor = 1'b0;
        drive_d.adc_sel = {1'b0, ctrl_q.asel};
      end
    endcase
  end

  // Switch drive register
  // Registered so the analog switches never see decode glitches
  always_ff @(posedge core_clk) begin
    if (reset) begin
      drive_q <= '0;
    end else begin
      drive_q <= drive_d;
    end
  end

  // ==========================================================
  // Outputs straight from flops
  assign reg_rdata = rdata_q;
  assign drive = drive_q;
  assign panel_event = event_q;

endmodule : rtpc_ctrl

// ==== rtpc_pkg.sv ====
/*
  Shared constants, field layouts and carrier types for the resistive
  touch panel control block.
  Assumes a 32-bit plain register port with byte addresses on word bounds.
*/
package rtpc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] RTPC_CTRL_OFS = 8'h00; // Panel control
  localparam logic [7:0] RTPC_STAT_OFS = 8'h04; // Event status

  // ==========================================================
  // Control field positions
  localparam int RTPC_PWR_LSB = 0;   // Four terminal_power_bit
  localparam int RTPC_GND_LSB = 4;   // Four terminal_ground_bit
  localparam int RTPC_MODE_LSB = 8;  // Two-bit mode select
  localparam int RTPC_ASEL_LSB = 10; // Two-bit converter input select
  localparam int RTPC_RISE_BIT = 12; // Release edge enable
  localparam int RTPC_FALL_BIT = 13; // Press edge enable
  localparam logic [31:0] RTPC_CTRL_RST = 32'h0000_0000;

  // ==========================================================
  // Status field positions
  localparam int RTPC_PRESS_BIT = 0;   // Sticky press event
  localparam int RTPC_RELEASE_BIT = 1; // Sticky release event
  localparam int RTPC_LEVEL_BIT = 2;   // Synced touch-detect level

  // ==========================================================
  // Mode encodings
  localparam logic [1:0] RTPC_MODE_DETECT = 2'h0;   // Resistor bias
  localparam logic [1:0] RTPC_MODE_PRESSURE = 2'h1; // Current monitor
  localparam logic [1:0] RTPC_MODE_POS_A = 2'h2;    // Position
  localparam logic [1:0] RTPC_MODE_POS_B = 2'h3;    // Position

  // Converter input code for the current monitor
  localparam logic [2:0] RTPC_ADC_CURRENT = 3'h4;

  // Panel control fields
  typedef struct packed {
    logic fall_en;      // Press edge enable
    logic rise_en;      // Release edge enable
    logic [1:0] asel;   // Terminal routed to converter
    logic [1:0] mode;   // Mode select
    logic [3:0] gnd;    // Per-terminal ground bits
    logic [3:0] pwr;    // Per-terminal power bits
  } rtpc_ctrl_t;

  // Drive set towards the analog switch matrix
  typedef struct packed {
    logic [3:0] pwr_on;   // Terminal switched to power
    logic [3:0] gnd_on;   // Terminal switched to ground
    logic bias_active;    // Active bias circuit on
    logic bias_resistor;  // Resistor bias on
    logic [2:0] adc_sel;  // Converter input, 0..3 terminal, 4 current
  } rtpc_drive_t;

endpackage : rtpc_pkg

// ==== rtpc_sync.sv ====
/*
  Two-stage synchroniser for asynchronous comparator levels.
  Assumes inputs are levels from outside the core_clk domain.
*/
`timescale 1ns/100ps
module rtpc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q; // First stage, read only by second
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q; // Second stage
  logic [WIDTH-1:0] sync_d;

  // ==========================================================
  // Next values
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Registers; idle level is high (panel untouched)
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : rtpc_sync

// ==== rtpc_assertions.sv ====
/* Port checker for rtpc_ctrl.
   Assumes one clock, sync reset, bound to every rtpc_ctrl. */
`timescale 1ns/100ps
module rtpc_chk
  import rtpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic standby,
  input wire logic cmp_xp,
  input wire logic cmp_xm,
  input wire rtpc_drive_t drive,
  input wire logic panel_event
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ==========
  // Helpers: detect level, control write, enable shadows
  logic lvl, wc, fen_q, ren_q;
  assign lvl = cmp_xp & cmp_xm;
  assign wc = reg_wr && reg_addr == RTPC_CTRL_OFS;
  // Shadow lands with the control register itself
  always_ff @(posedge core_clk) begin
    if (reset) {fen_q, ren_q} <= 2'h0;
    else if (wc) {fen_q, ren_q} <= reg_wdata[13:12];
  end
  // ==========
  // Switch matrix and routing, two edges after a write
  property p_gnd; (drive.pwr_on & drive.gnd_on) == 4'h0; endproperty
  a_gnd: assert property (p_gnd) else $error("power with ground");
  property p_sw; $past(wc, 2) |-> drive.gnd_on == $past(reg_wdata[7:4], 2)
    && drive.pwr_on == $past(reg_wdata[3:0] & ~reg_wdata[7:4], 2); endproperty
  a_sw: assert property (p_sw) else $error("bad matrix");
  property p_route; $past(wc && reg_wdata[9:8] != 2'h0, 2) |-> drive.adc_sel ==
    ($past(reg_wdata[9], 2) ? {1'b0, $past(reg_wdata[11:10], 2)} : 3'h4); endproperty
  a_route: assert property (p_route) else $error("bad route");
  property p_bias; $past(wc, 2) |-> drive.bias_resistor == !$past(|reg_wdata[9:8], 2);
  endproperty
  a_bias: assert property (p_bias) else $error("bad bias");
  // ==========
  // Events: three edges from pin to pulse
  property p_press; fen_q && $past(lvl, 4) && !$past(lvl, 3) |-> panel_event; endproperty
  a_press: assert property (p_press) else $error("press lost");
  property p_rel; ren_q && !$past(lvl, 4) && $past(lvl, 3) |-> panel_event; endproperty
  a_rel: assert property (p_rel) else $error("release lost");
  property p_cause; panel_event |-> $past(lvl, 3) != $past(lvl, 4)
    && ($past(lvl, 3) ? ren_q : fen_q); endproperty
  a_cause: assert property (p_cause) else $error("stray event");
  property p_pulse; panel_event |=> !panel_event; endproperty
  a_pulse: assert property (p_pulse) else $error("long event");
  c_press: cover property (fen_q && panel_event && !$past(lvl, 3));
  c_rel: cover property (ren_q && panel_event && $past(lvl, 3));
  c_cur: cover property (drive.adc_sel == RTPC_ADC_CURRENT);
endmodule : rtpc_chk
bind rtpc_ctrl rtpc_chk i_rtpc_chk (.core_clk(core_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .standby(standby), .cmp_xp(cmp_xp), .cmp_xm(cmp_xm),
  .drive(drive), .panel_event(panel_event));

// ==== rtpc_panel.sv ====
/* Four-wire panel model driving the X comparator pins.
   Assumes the bench sets touched. */
`timescale 1ns/100ps
module rtpc_panel
  import rtpc_pkg::*;
(
  input wire rtpc_drive_t drive,
  input wire logic touched,
  output logic cmp_xp,
  output logic cmp_xm
);
  // X plate pulled low only via a grounded Y terminal
  assign cmp_xp = !(touched && (drive.gnd_on[2] || drive.gnd_on[3]));
  assign cmp_xm = cmp_xp;
endmodule : rtpc_panel

// ==== tb_rtpc_ctrl.sv ====
/* Bench for rtpc_ctrl with the panel model.
   Assumes the checker is bound in. */
`timescale 1ns/100ps
module tb_rtpc_ctrl
  import rtpc_pkg::*;
;
  logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, p1 = 1'b0;
  logic standby = 1'b0, touched = 1'b0, cmp_xp, cmp_xm, panel_event;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, r = 32'hfcbc;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  logic ev_q[$]; // Expected X pin level at each event, oldest first
  rtpc_drive_t drive;
  int n_fail = 0, tests_run = 0;
  always #25 core_clk = ~core_clk;
  rtpc_ctrl i_rtpc_ctrl (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .standby(standby), .cmp_xp(cmp_xp), .cmp_xm(cmp_xm), .drive(drive),
    .panel_event(panel_event));
  rtpc_panel i_rtpc_panel (.drive(drive), .touched(touched), .cmp_xp(cmp_xp),
    .cmp_xm(cmp_xm));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // One bus cycle; a read notes its expected data
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    if (!w) exp_q.push_back(d);
    @(posedge core_clk);
    {reg_wr, reg_rd} <= 2'h0;
  endtask : bus
  // Touch or lift, then read and clear the sticky status
  task automatic touch(input logic t, input logic [31:0] st);
    @(posedge core_clk);
    touched <= t;
    // An enabled edge notes the pin level it leaves behind
    if (st[1:0] != 2'h0) ev_q.push_back(!t);
    repeat (6) @(posedge core_clk);
    check(ev_q.size(), 32'h0);
    bus(1'b0, RTPC_STAT_OFS, st);
    bus(1'b1, RTPC_STAT_OFS, 32'h3);
  endtask : touch
  // Write a measurement setup and check the drive it gives, bias off standby
  task automatic meas(input logic [31:0] cfg, input logic [3:0] pw, input logic [3:0] gd,
    input logic [2:0] sel);
    bus(1'b1, RTPC_CTRL_OFS, cfg);
    repeat (2) @(posedge core_clk);
    #1;
    check({drive.pwr_on, drive.gnd_on}, {pw, gd});
    check({drive.bias_active, drive.bias_resistor, drive.adc_sel}, {2'b10, sel});
  endtask : meas
  // Read data stand in the one cycle after the strobe is taken
  always @(negedge core_clk) begin
    if (p1) check(reg_rdata, exp_q.pop_front());
    p1 = reg_rd;
  end
  // Each event pulse takes the oldest expected pin level
  always @(negedge core_clk) begin
    if (panel_event && ev_q.size() == 0) check(32'h1, 32'h0);
    else if (panel_event) check(cmp_xp, ev_q.pop_front());
  end
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    bus(1'b0, RTPC_CTRL_OFS, 32'h0);
    bus(1'b0, RTPC_STAT_OFS, 32'h4);
    bus(1'b0, 8'h08, 32'h0);
    // Random matrix, routing and standby across all four modes
    for (int i = 0; i < 12; i++) begin
      r = lfsr(r);
      r[9:8] = i[1:0];
      standby <= r[16];
      bus(1'b1, RTPC_CTRL_OFS, r);
      repeat (2) @(posedge core_clk);
      #1;
      check({drive.pwr_on, drive.gnd_on}, {r[3:0] & ~r[7:4], r[7:4]});
      check({drive.bias_active, drive.bias_resistor, drive.adc_sel}, {i[1:0] != 0 && !r[16],
        i[1:0] == 0, i[1:0] == 1 ? 3'h4 : {1'b0, r[11:10]}});
      bus(1'b0, RTPC_CTRL_OFS, r & 32'h3fff);
    end
    // Host measurement sequences with the active bias on
    standby <= 1'b0;
    meas(32'h0000_0a21, 4'h1, 4'h2, 3'h2); // X plate biased, Y sampled
    meas(32'h0000_0284, 4'h4, 4'h8, 3'h0); // Y plate biased, X sampled
    meas(32'h0000_01c3, 4'h3, 4'hc, 3'h4); // pressure, current read
    meas(32'h0000_0121, 4'h1, 4'h2, 3'h4); // Y plate left floating
    // detect setup: X powered, Y grounded, resistor bias, standby on
    standby <= 1'b1;
    bus(1'b1, RTPC_CTRL_OFS, 32'h30c3);
    repeat (2) @(posedge core_clk);
    #1;
    check({drive.bias_active, drive.bias_resistor}, 2'b01);
    touch(1'b1, 32'h1);
    touch(1'b0, 32'h6);
    bus(1'b1, RTPC_CTRL_OFS, 32'h20c3);
    touch(1'b1, 32'h1);
    touch(1'b0, 32'h4);
    repeat (4) @(posedge core_clk);
    check(exp_q.size(), 32'h0);
    finish_test();
  end
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule : tb_rtpc_ctrl
